// [core/ssm_monitor.sv]
// Serial switch input monitor: snapshot, shift out, change interrupt
// How it works
// - Input count is sixteen or eight, parameter
// - Select falling edge snapshots inputs into status
// - Select falling edge clears pending change interrupt
// - Serial clock and data ignored while deselected
// - First clock rise loads shift register
// - Later clock rises shift toward output
// - Clock fall samples serial input
// - Serial input matters only while selected
// - Serial output floats while deselected
// - Output shows shift MSB after each rise
// - Interrupt low while live inputs differ
// - Interrupt enable low floats interrupt
// - Interrupt is open-drain, active low
// - Input vector is count-1 down to zero
`include "ssm_regs.svh"

module ssm_monitor #(
    parameter int INPUT_COUNT = `SSM_INPUTS_WIDE,  // 16 or 8 inputs
    parameter int FIFO_DEPTH  = `SSM_FIFO_DEPTH    // Record buffer depth
) (
    input  wire logic                   core_clk,         // Core clock, 125 MHz
    input  wire logic                   sys_rst,          // Synchronous reset
    input  wire logic                   clk_en,           // Freezes all state
    input  wire ssm_pkg::ssm_spi_pins_t spi_pins,         // Serial pins, async
    input  wire logic [INPUT_COUNT-1:0] switch_inputs,    // Switch levels, async
    input  wire logic                   int_enable,       // Interrupt enable pin
    output logic                        serial_chain_output,      // Serial out
    output logic                        serial_chain_output_oe_n, // Low drives
    output logic                        change_int_n,     // Open-drain level
    output logic                        change_int_oe_n,  // Low pulls line
    output logic                        rec_valid,        // Record available
    input  wire logic                   rec_ready,        // Record taken
    output ssm_pkg::ssm_record_t        rec_data,         // Record contents
    output logic                        rec_dropped       // Lost record pulse
);
    import ssm_pkg::*;

    localparam int N = INPUT_COUNT;
    localparam int W = `SSM_INPUTS_WIDE;

    // Widen an input-sized vector to the record field
    function automatic logic [W-1:0] widen(input logic [N-1:0] v);
        logic [W-1:0] r;
        r = '0;
        r[N-1:0] = v;
        return r;
    endfunction

    // Synchroniser stages; the first stage feeds only the second
    logic [N-1:0] sw_meta;     // Switch first stage
    logic [N-1:0] sw_sync;     // Switch levels, safe to use
    logic         cs_meta;     // Select first stage
    logic         cs_sync;     // Select, safe
    logic         cs_prev;     // Select, one cycle older
    logic         sclk_meta;   // Clock first stage
    logic         sclk_sync;   // Clock, safe
    logic         sclk_prev;   // Clock, one cycle older
    logic         din_meta;    // Data first stage
    logic         din_sync;    // Data, safe
    logic         en_meta;     // Enable first stage
    logic         en_sync;     // Enable, safe

    // Block state
    ssm_state_t   state;       // Access sequencer
    ssm_state_t   next_state;  // Sequencer next value
    logic [N-1:0] status;      // Input status register
    logic [N-1:0] shreg;       // Shift register
    logic         sample_bit;  // Last bit sampled on clock fall
    logic [N-1:0] rx_acc;      // Bits received this access
    logic         int_active;  // Change interrupt pulling
    logic         push_pending;// Record waiting for buffer space
    ssm_record_t  push_rec;    // Record waiting

    // Pin synchronisers: two flops before any logic looks
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sw_meta   <= '0;
            sw_sync   <= '0;
            cs_meta   <= 1'b1;
            cs_sync   <= 1'b1;
            cs_prev   <= 1'b1;
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
            din_meta  <= 1'b0;
            din_sync  <= 1'b0;
            en_meta   <= 1'b0;
            en_sync   <= 1'b0;
        end
        else if (clk_en)
        begin
            sw_meta   <= switch_inputs;
            sw_sync   <= sw_meta;
            cs_meta   <= spi_pins.cs_n;
            cs_sync   <= cs_meta;
            cs_prev   <= cs_sync;
            sclk_meta <= spi_pins.sclk;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
            din_meta  <= spi_pins.serial_chain_input;
            din_sync  <= din_meta;
            en_meta   <= int_enable;
            en_sync   <= en_meta;
        end
    end

    // Edge decode; equal sync depth keeps select and clock in order
    wire selected  = ~cs_sync;
    wire cs_fall   = cs_prev & ~cs_sync;
    wire cs_rise   = ~cs_prev & cs_sync;
    wire sclk_rise = selected & ~sclk_prev & sclk_sync;
    wire sclk_fall = selected & sclk_prev & ~sclk_sync;

    // Snapshot decode and change compare against the new status
    wire [N-1:0] next_status = cs_fall ? sw_sync : status;
    wire         mismatch    = |(sw_sync ^ next_status);
    wire         next_int    = en_sync & mismatch;
    wire         access_done = cs_rise & (state != SSM_IDLE);
    wire         fifo_ready;

    // Shift register next value
    wire [N-1:0] next_shreg =
        (sclk_rise && state == SSM_ARMED)    ? status :
        (sclk_rise && state == SSM_SHIFTING) ? {shreg[N-2:0], sample_bit}
                                             : shreg;

    // Sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            SSM_IDLE:
            begin
                if (cs_fall)
                    next_state = SSM_ARMED;
            end
            SSM_ARMED:
            begin
                if (!selected)
                    next_state = SSM_IDLE;
                else if (sclk_rise)
                    next_state = SSM_SHIFTING;
            end
            SSM_SHIFTING:
            begin
                if (!selected)
                    next_state = SSM_IDLE;
            end
            default:
                next_state = SSM_IDLE;
        endcase
    end

    // Status, shift path and interrupt
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state      <= SSM_IDLE;
            status     <= N'(`SSM_STATUS_RST);
            shreg      <= N'(`SSM_SHIFT_RST);
            sample_bit <= 1'b0;
            rx_acc     <= '0;
            int_active <= 1'b0;
        end
        else if (clk_en)
        begin
            state      <= next_state;
            status     <= next_status;
            shreg      <= next_shreg;
            int_active <= next_int;
            if (cs_fall)
                rx_acc <= '0;
            if (sclk_fall)
            begin
                sample_bit <= din_sync;
                rx_acc     <= {rx_acc[N-2:0], din_sync};
            end
        end
    end

    // Pin drivers, all from flops
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            serial_chain_output      <= 1'b0;
            serial_chain_output_oe_n <= 1'b1;
            change_int_oe_n          <= 1'b1;
        end
        else if (clk_en)
        begin
            serial_chain_output      <= next_shreg[N-1];
            serial_chain_output_oe_n <= cs_sync;
            change_int_oe_n          <= ~next_int;
        end
    end

    // Open-drain: the pin value is always low, only the enable moves
    assign change_int_n = 1'b0;

    // Record hand-off; a held record waits for buffer room, but the next finished access replaces it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            push_pending <= 1'b0;
            push_rec     <= '0;
            rec_dropped  <= 1'b0;
        end
        else if (clk_en)
        begin
            rec_dropped <= access_done & push_pending & ~fifo_ready;
            if (access_done)
            begin
                push_pending      <= 1'b1;
                push_rec.snapshot <= widen(status);
                push_rec.chain_rx <= widen(rx_acc);
            end
            else if (fifo_ready)
                push_pending <= 1'b0;
        end
    end

    // Buffer between access completion and the user side
    ssm_fifo #(
        .WIDTH ($bits(ssm_record_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_valid  (push_pending),
        .in_ready  (fifo_ready),
        .in_data   (push_rec),
        .out_valid (rec_valid),
        .out_ready (rec_ready),
        .out_data  (rec_data)
    );

    // Checks next to the logic they guard
    a_snap_on_select: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && cs_fall) |=> (status == $past(sw_sync)))
        else $error("snapshot not taken on select");

    a_int_clear_select: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && cs_fall) |=> change_int_oe_n)
        else $error("interrupt not cleared on select");

    a_idle_ignores_clock: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && state == SSM_IDLE && !cs_fall) |=> $stable(shreg) && $stable(sample_bit))
        else $error("serial activity acted on while idle");

    a_first_rise_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && state == SSM_ARMED && sclk_rise)
            |=> (shreg == $past(status)) && (state == SSM_SHIFTING))
        else $error("first rise did not load");

    a_shift_one_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && state == SSM_SHIFTING && sclk_rise)
            |=> (shreg == {$past(shreg[N-2:0]), $past(sample_bit)}))
        else $error("shift step wrong");

    a_fall_sample: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && sclk_fall) |=> (sample_bit == $past(din_sync)))
        else $error("serial input not sampled on fall");

    a_deselect_float: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && cs_sync) |=> serial_chain_output_oe_n)
        else $error("serial output driven while deselected");

    a_msb_presented: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && sclk_rise) |=> (serial_chain_output == shreg[N-1]))
        else $error("output does not show shift MSB");

    a_int_mismatch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && en_sync && !cs_fall && (sw_sync != status)) |=> !change_int_oe_n)
        else $error("interrupt missing on input change");

    a_int_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && !en_sync) |=> change_int_oe_n)
        else $error("interrupt pulls while disabled");

    a_int_open_drain: assert property (@(posedge core_clk) disable iff (sys_rst)
        (change_int_n == 1'b0) && (change_int_oe_n == !int_active))
        else $error("interrupt pin not open-drain");

    c_full_access: cover property (@(posedge core_clk) disable iff (sys_rst)
        (state == SSM_SHIFTING) ##1 access_done);
    c_int_raised: cover property (@(posedge core_clk) disable iff (sys_rst)
        change_int_oe_n ##1 !change_int_oe_n);
    c_record_out: cover property (@(posedge core_clk) disable iff (sys_rst)
        rec_valid && rec_ready);
    c_record_lost: cover property (@(posedge core_clk) disable iff (sys_rst)
        rec_dropped);

endmodule

// [core/ssm_regs.svh]
// Constants for the serial switch input monitor
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

`define SSM_INPUTS_WIDE     16        // Input count, wide variant
`define SSM_INPUTS_NARROW   8         // Input count, narrow variant
`define SSM_FIFO_DEPTH      8         // Words held in the record buffer
`define SSM_STATUS_RST      16'h0000  // Status register after reset
`define SSM_SHIFT_RST       16'h0000  // Shift register after reset
`define SSM_SYNC_STAGES     2         // Flip-flops in each pin synchroniser

`endif

// [core/ssm_pkg.sv]
// Types shared by the serial switch input monitor
`include "ssm_regs.svh"

package ssm_pkg;

    // Access sequencer states
    typedef enum logic [1:0]
    {
        SSM_IDLE,      // Deselected, serial lines ignored
        SSM_ARMED,     // Selected, waiting for first clock rise
        SSM_SHIFTING   // Shift register loaded, shifting out
    } ssm_state_t;

    // Serial pins as seen from the device
    typedef struct packed
    {
        logic cs_n;                // Chip select, active low
        logic sclk;                // Serial clock from controller
        logic serial_chain_input;  // Serial data in
    } ssm_spi_pins_t;

    // One finished access, handed to the user side
    typedef struct packed
    {
        logic [`SSM_INPUTS_WIDE-1:0] snapshot;  // Captured switch levels
        logic [`SSM_INPUTS_WIDE-1:0] chain_rx;  // Bits shifted in, last in LSB
    } ssm_record_t;

endpackage

// [core/ssm_fifo.sv]
// Record buffer with its own memory and a registered read port
`include "ssm_regs.svh"

module ssm_fifo #(
    parameter int WIDTH = 32,               // Word width
    parameter int DEPTH = `SSM_FIFO_DEPTH   // Words in memory, power of two
) (
    input  wire logic             core_clk,  // Core clock
    input  wire logic             sys_rst,   // Synchronous reset, high
    input  wire logic             clk_en,    // Freezes all state when low
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Space available
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    output logic                  out_valid, // Read data present
    input  wire logic             out_ready, // Consumer takes the word
    output logic      [WIDTH-1:0] out_data   // Read data, from a register
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Storage, no reset needed
    logic [AW:0]      wr_ptr;        // Write pointer with wrap bit
    logic [AW:0]      rd_ptr;        // Read pointer with wrap bit

    // Occupancy decode
    wire [AW:0] fill      = wr_ptr - rd_ptr;
    wire        mem_full  = (fill == (AW+1)'(DEPTH));
    wire        mem_empty = (wr_ptr == rd_ptr);
    wire        wr_en     = in_valid & ~mem_full & clk_en;
    wire        rd_en     = ~mem_empty & (~out_valid | out_ready) & clk_en;

    assign in_ready = ~mem_full;

    // Memory write port
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    // Pointers
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (wr_en)
                wr_ptr <= wr_ptr + 1'b1;
            if (rd_en)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Output stage; one more word waits here beyond the memory
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            out_valid <= 1'b0;
        else if (rd_en)
            out_valid <= 1'b1;
        else if (clk_en && out_ready)
            out_valid <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rd_en)
            out_data <= mem[rd_ptr[AW-1:0]];
    end

endmodule

// [tb/ssm_spi_ctrl.sv]
// Behavioural SPI controller that drives the monitor's serial pins
module ssm_spi_ctrl (
    output ssm_pkg::ssm_spi_pins_t pins,      // Chip select, clock and data out
    input  wire logic              sdo,       // Device serial output
    input  wire logic              sdo_oe_n   // Low while device drives it
);
    timeunit 1ns;
    timeprecision 100ps;
    import ssm_pkg::*;

    // Idle bus: deselected, clock parked low, data at its pull-down level
    initial
    begin
        pins = '{cs_n: 1'b1, sclk: 1'b0, serial_chain_input: 1'b0};
    end

    // Select with the clock held low across the edge
    task automatic select();
        pins.sclk = 1'b0;
        pins.cs_n = 1'b0;
        #40;
    endtask

    // Deselect after a low-clock settling time, data back to pull-down
    task automatic deselect();
        #40;
        pins.cs_n = 1'b1;
        #40;
        pins.serial_chain_input = 1'b0;
    endtask

    // Clock n bits at 80 ns; tx goes MSB first, rx collects MSB first
    task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        for (int k = 0; k < n; k++)
        begin
            pins.serial_chain_input = tx[n-1-k];
            pins.sclk = 1'b1;
            #40;
            // A floating output must never read as data
            rx = {rx[30:0], (sdo_oe_n === 1'b0) ? sdo : 1'bx};
            pins.sclk = 1'b0;
            #40;
        end
    endtask

    // Clock and data activity while deselected, far from select edges
    task automatic wiggle(input int n);
        for (int k = 0; k < n; k++)
        begin
            pins.serial_chain_input = k[0];
            pins.sclk = 1'b1;
            #40;
            pins.sclk = 1'b0;
            #40;
        end
        pins.serial_chain_input = 1'b0;
    endtask
endmodule

// [tb/spi_switch_input_monitor_tb.sv]
// Self-checking bench: wide monitor chained into a narrow one
module spi_switch_input_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ssm_pkg::*;

    logic          core_clk, sys_rst, clk_en, int_enable, rec_ready, rec_valid, rec_dropped;
    logic [15:0]   sw;              // Switch levels
    logic          sdo, sdo_oe_n, int_n, int_oe_n;
    ssm_spi_pins_t pins, n_pins;    // Controller pins, narrow device pins
    ssm_record_t   rec_data, n_rec_data, n_last;
    logic          n_valid;
    wire           int_line = int_oe_n ? 1'b1 : int_n;   // Pull-up resolves open drain
    wire           chain_line = sdo_oe_n ? 1'b0 : sdo;   // Pull-down on next input
    int            errors, check_count, drops, cycles;
    ssm_record_t   recs[$];         // Records taken from the wide device

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ssm_spi_ctrl ctrl (.pins(pins), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

    ssm_monitor #(.INPUT_COUNT(16), .FIFO_DEPTH(8)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .spi_pins(pins),
        .switch_inputs(sw), .int_enable(int_enable), .serial_chain_output(sdo),
        .serial_chain_output_oe_n(sdo_oe_n), .change_int_n(int_n),
        .change_int_oe_n(int_oe_n), .rec_valid(rec_valid), .rec_ready(rec_ready),
        .rec_data(rec_data), .rec_dropped(rec_dropped));

    // Second device shares select and clock, fed from the first one's output
    assign n_pins = {pins.cs_n, pins.sclk, chain_line};
    ssm_monitor #(.INPUT_COUNT(8), .FIFO_DEPTH(8)) dut_narrow (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .spi_pins(n_pins),
        .switch_inputs(sw[7:0]), .int_enable(int_enable), .serial_chain_output(),
        .serial_chain_output_oe_n(), .change_int_n(), .change_int_oe_n(),
        .rec_valid(n_valid), .rec_ready(1'b1), .rec_data(n_rec_data), .rec_dropped());

    // Narrow records are always accepted; keep the newest one
    always @(posedge core_clk)
    begin
        if (n_valid === 1'b1) n_last <= n_rec_data;
        // A pulse held through a frozen stretch is still one lost record
        if (rec_dropped === 1'b1 && clk_en === 1'b1) drops <= drops + 1;
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            errors++;
            $display("wrong value at %0t: run did not finish in time", $time);
            summarize();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Accept records with ready held high for a number of cycles
    task automatic collect(input int n);
        rec_ready = 1'b1;
        repeat (n)
        begin
            if (rec_valid === 1'b1) recs.push_back(rec_data);
            step(1);
        end
        rec_ready = 1'b0;
    endtask

    // Snapshot, shift-out order and record contents of a plain read
    task automatic t_read();
        logic [31:0] rx;
        sw = 16'ha5c3;
        step(8);
        check_bit(int_line, 1'b0, "int on change");
        ctrl.select();
        step(1);
        check_bit(sdo_oe_n, 1'b0, "output driven");
        check_bit(int_line, 1'b1, "int cleared");
        sw = 16'h0000;
        ctrl.shift(16, 32'h3c96, rx);
        check_word(rx, 32'ha5c3, "shifted status");
        ctrl.deselect();
        step(4);
        check_bit(sdo_oe_n, 1'b1, "output floats");
        collect(20);
        check_word(recs.size(), 1, "record count");
        check_word(recs.pop_front(), {16'ha5c3, 16'h3c96}, "wide record");
        check_word(n_last, {16'h00c3, 16'h00c3}, "narrow record");
        $display("test read done");
    endtask

    // Enable gating, release on match, clear by select fall
    task automatic t_int();
        logic [31:0] rx;
        check_bit(int_line, 1'b0, "int on mismatch");
        check_bit(int_n, 1'b0, "pin only pulls low");
        int_enable = 1'b0;
        step(5);
        check_bit(int_line, 1'b1, "int disabled");
        int_enable = 1'b1;
        step(5);
        check_bit(int_line, 1'b0, "int enabled");
        sw = 16'ha5c3;
        step(5);
        check_bit(int_line, 1'b1, "int on match");
        sw = 16'h8000;
        step(5);
        check_bit(int_line, 1'b0, "int on top input");
        ctrl.select();
        step(1);
        check_bit(int_line, 1'b1, "int cleared");
        ctrl.shift(16, 32'h0, rx);
        check_word(rx, 32'h8000, "top input first");
        ctrl.deselect();
        collect(20);
        recs.delete();
        $display("test int done");
    endtask

    // Serial activity while deselected leaves no trace
    task automatic t_ignore();
        logic [31:0] rx;
        ctrl.wiggle(8);
        collect(30);
        check_word(recs.size(), 0, "no record while idle");
        ctrl.select();
        ctrl.shift(16, 32'h0, rx);
        check_word(rx, 32'h8000, "status untouched");
        ctrl.deselect();
        collect(20);
        check_word(recs.pop_front(), {16'h8000, 16'h0000}, "idle data ignored");
        $display("test ignore done");
    endtask

    // Thirty-two clocks return the status, then the controller's data sixteen clocks late
    task automatic t_chain();
        logic [31:0] rx;
        sw = 16'h1234;
        ctrl.select();
        ctrl.shift(32, 32'hcafe0f0f, rx);
        check_word(rx, 32'h1234cafe, "chain delay");
        ctrl.deselect();
        collect(20);
        check_word(recs.pop_front(), {16'h1234, 16'h0f0f}, "last bits kept");
        $display("test chain done");
    endtask

    // Eleven accesses with the consumer stalled, then a full drain
    task automatic t_fifo();
        logic [31:0] rx;
        for (int i = 0; i < 11; i++)
        begin
            sw = i[15:0];
            step(6);
            ctrl.select();
            ctrl.shift(1, 32'h1, rx);
            ctrl.deselect();
        end
        step(10);
        check_word(drops, 1, "one record lost");
        collect(80);
        check_word(recs.size(), 10, "records held");
        // Held record of the tenth access is the one overwritten
        for (int k = 0; k < 10; k++)
            check_word(recs[k].snapshot, (k < 9) ? k : 10, "record order");
        $display("test fifo done");
    endtask

    // Clock enable freezes the block; a mid-run reset starts it afresh
    task automatic t_freeze();
        logic [31:0] rx;
        recs.delete();
        clk_en = 1'b0;
        sw = 16'hffff;
        step(8);
        check_bit(int_line, 1'b1, "int frozen");
        clk_en = 1'b1;
        step(5);
        check_bit(int_line, 1'b0, "int after thaw");
        sys_rst = 1'b1;
        step(2);
        check_bit(int_line, 1'b1, "int in reset");
        check_bit(sdo_oe_n, 1'b1, "output floats in reset");
        sys_rst = 1'b0;
        step(1);
        check_bit(int_line, 1'b1, "int one edge after reset");
        step(5);
        check_bit(int_line, 1'b0, "int against reset status");
        ctrl.select();
        ctrl.shift(16, 32'h0, rx);
        check_word(rx, 32'hffff, "snapshot after reset");
        ctrl.deselect();
        collect(20);
        check_word(recs.size(), 1, "record after reset");
        check_word(recs.pop_front(), {16'hffff, 16'h0000}, "reset record");
        $display("test freeze done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        sw = 16'h0000;
        int_enable = 1'b1;
        rec_ready = 1'b0;
        errors = 0;
        check_count = 0;
        drops = 0;
        cycles = 0;
        step(8);
        sys_rst = 1'b0;
        step(6);
        check_bit(sdo_oe_n, 1'b1, "output floats after reset");
        check_bit(int_line, 1'b1, "int idle after reset");
        t_read();
        t_int();
        t_ignore();
        t_chain();
        t_fifo();
        t_freeze();
        summarize();
    end
endmodule
